/* File: spi_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Serial peripheral on the far side of the link: shifts its byte out while capturing ours
module spi_far_model (
   input wire logic sck,
   input wire logic mosi,
   input wire logic pol,
   input wire logic pha,
   input wire logic load,
   input wire logic [7:0] load_val,
   output logic miso,
   output logic [7:0] rx_q
);
   logic [7:0] tx_q;
   initial begin
      tx_q = 8'h00;
      rx_q = 8'h00;
      miso = 1'b0;
   end
   always @(posedge load) begin
      tx_q = load_val;
      rx_q = 8'h00;
      miso = load_val[7];
   end
   // Leading edge leaves the idle level; filler bits avoid a frozen line
   always @(sck) begin
      if (sck !== pol) begin
         if (!pha) begin
            rx_q = {rx_q[6:0], mosi};
         end else begin
            miso = tx_q[7];
            tx_q = {tx_q[6:0], ~tx_q[0]};
         end
      end else begin
         if (!pha) begin
            tx_q = {tx_q[6:0], ~tx_q[0]};
            miso = tx_q[7];
         end else begin
            rx_q = {rx_q[6:0], mosi};
         end
      end
   end
endmodule
`default_nettype wire

/* File: spi_glitch_filt.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_glitch_filt #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic en,
   input wire logic tick,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   if (W < 1) begin : g_chk
      $error("spi_glitch_filt: W must be at least 1");
   end
   typedef struct packed {
      logic [W-1:0] smp;
      logic [W-1:0] flt;
   } spi_filt_s;
   spi_filt_s q, d;
   always_comb begin
      d = q;
      if (tick) begin
         d.smp = din;
         // Output follows only a level seen on two core ticks running
         for (int i = 0; i < W; i++) begin
            if (din[i] == q.smp[i]) begin
               d.flt[i] = din[i]; // [R8]
            end
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign dout = en ? q.flt : din; // [R8]
   filt_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      en && $past(en) && q.flt != $past(q.flt) |-> $past(q.smp) == q.flt) else $error("filter passed a glitch"); // [R8]
endmodule
`default_nettype wire

/* File: spi_pkg.sv */
`default_nettype none
package spi_pkg;
   // Register map, byte addresses on the register bus
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_DIV = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_MISC = 8'h0c;
   localparam logic [7:0] ADDR_STS = 8'h10;
   localparam logic [7:0] ADDR_ICLR = 8'h14;
   localparam logic [7:0] ADDR_IEN = 8'h18;
   // serial_mode_control fields
   localparam int MODE_PHA = 0;
   localparam int MODE_POL = 1;
   localparam int MODE_CLK_SEL = 2;
   localparam int MODE_RX_EN = 3;
   localparam int MODE_STRT = 4;
   localparam int MODE_FILT = 5;
   localparam int MODE_IE = 6;
   localparam int MODE_RUN = 7;
   // serial_rate_frame_divider fields
   localparam int DIV_RATE_LSB = 0;
   localparam int DIV_FRAME_LSB = 3;
   localparam int DIV_FLAG = 7;
   // Interrupt status bits
   localparam int STS_DONE = 0;
   localparam int STS_ABORT = 1;
   // Values after reset
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_DIV = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [1:0] RST_IEN = 2'h0;
   // Core cycle clock is clk_sys divided by this count
   localparam logic [3:0] CORE_DIV = 4'hd;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_SHIFT = 2'b10
   } spi_state_e;
endpackage
`default_nettype wire

/* File: spi_rate_div.sv */
`timescale 1ns/10ps
`default_nettype none
module spi_rate_div
   import spi_pkg::*;
#(
   parameter int CNT_W = 12
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   spi_tick_if.gen tk
);
   if ((32'(CORE_DIV) << 8) > (2 ** CNT_W)) begin : g_chk
      $error("spi_rate_div: CNT_W too small");
   end
   typedef struct packed {
      logic [3:0] pre;
      logic [CNT_W-1:0] cnt;
   } spi_div_s;
   spi_div_s q, d;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] half;
   logic [3:0] shift;
   always_comb begin
      // Codes 0..6 give powers of two, code 7 gives 256
      shift = (tk.rate == 3'h7) ? 4'h8 : {1'h0, tk.rate}; // [R14]
      period = CNT_W'(CORE_DIV) << shift; // [R3]
      half = period >> 1;
      d = q;
      d.pre = (q.pre == CORE_DIV - 4'h1) ? 4'h0 : q.pre + 4'h1;
      if (!tk.run || q.cnt == period - CNT_W'(1)) begin
         d.cnt = '0;
      end else begin
         d.cnt = q.cnt + CNT_W'(1);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign tk.core_tick = (q.pre == CORE_DIV - 4'h1);
   assign tk.lead = tk.run && (q.cnt == half - CNT_W'(1));
   assign tk.trail = tk.run && (q.cnt == period - CNT_W'(1));
   lead_spacing_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tk.lead && tk.run |-> !tk.trail && q.cnt < period) else $error("lead and trail overlap"); // [R14]
endmodule
`default_nettype wire

/* File: spi_serial_port.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Phase clear: frame MSB appears on serial output as soon as shift register loads.
// R2: Phase set: frame MSB appears on serial output only at the first leading edge.
// R3: Base clock select picks divided core clock (master) or external clock pin (slave).
// R4: Selector low means clock pin input; high means driven clock shaped by polarity/phase.
// R5: Receive enable clear shifts in zero; set shifts in the serial input level.
// R6: Start mode clear starts on activity flag; set also waits for serial input high.
// R7: Once a gated transfer started, it completes even if serial input drops.
// R8: Filter enable suppresses data and clock input pulses shorter than one to two core cycles.
// R9: Polarity picks capture and change edges, and the idle level of the clock.
// R10: Divider register writes ignored while activity flag set; all bits reset to zero.
// R11: Shift data writes ignored while activity flag set; reads always allowed.
// R12: Transfer end sets divider bit 7 flag, interrupting if enabled; software clears it.
// R13: Frame length field bits 6..3 gives 1 to 15 bits; zero reserved, eight normal.
// R14: Rate field divides core clock by 1,2,4,8,16,32,64 or 256.
// R15: Shift register sends and receives most significant bit first.
// R16: Misc bit 0 set routes serial output to shared pin, clear leaves general purpose.
// R17: Transfer end clears activity flag; software clearing it aborts; both may interrupt.
// R18: Software must not combine gated start with receive enable; mode resets to zero.
// R19: Slave mode shifts on external clock edges; master supplies exactly frame length pulses.
module spi_serial_port
   import spi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic sin,
   input wire logic port_dout,
   input wire logic port_oe,
   output logic shared_pin_out,
   output logic shared_pin_oe
);
   typedef struct packed {
      spi_state_e state;
      logic [7:0] mode;
      logic [7:0] div;
      logic [7:0] sr;
      logic [7:0] misc;
      logic [1:0] sts;
      logic [1:0] ien;
      logic [3:0] bit_cnt;
      logic smp;
      logic out_q;
      logic lead_done;
      logic sck_q;
      logic sck_prev;
      logic sck_m;
      logic sck_s;
      logic sin_m;
      logic sin_s;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_be;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } spi_core_s;
   spi_core_s q, d;
   logic master;
   logic pol;
   logic pha;
   logic sin_f;
   logic sck_f;
   logic in_bit;
   logic lead_ev;
   logic trail_ev;
   logic go;
   logic wr_fire;
   logic wr_ok;
   logic end_ev;
   logic abort_ev;
   logic sout_int;
   logic [3:0] frame_len;
   logic [3:0] last_bit;
   logic [7:0] rd_val;
   logic rd_ok;
   spi_tick_if tk ();
   spi_rate_div #(
      .CNT_W(12)
   ) u_div (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tk(tk)
   );
   spi_glitch_filt #(
      .W(1)
   ) u_filt_sin (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .en(q.mode[MODE_FILT]),
      .tick(tk.core_tick),
      .din(q.sin_s),
      .dout(sin_f)
   );
   spi_glitch_filt #(
      .W(1)
   ) u_filt_sck (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .en(q.mode[MODE_FILT]),
      .tick(tk.core_tick),
      .din(q.sck_s),
      .dout(sck_f)
   );
   assign master = q.mode[MODE_CLK_SEL];
   assign pol = q.mode[MODE_POL];
   assign pha = q.mode[MODE_PHA];
   assign tk.run = (q.state == ST_SHIFT) && master;
   assign tk.rate = q.div[DIV_RATE_LSB +: 3];
   assign frame_len = q.div[DIV_FRAME_LSB +: 4];
   // A reserved zero length behaves as a single bit
   assign last_bit = (frame_len == 4'h0) ? 4'h0 : frame_len - 4'h1; // [R13]
   assign in_bit = q.mode[MODE_RX_EN] ? sin_f : 1'h0; // [R5]
   assign go = q.mode[MODE_RUN] && (!q.mode[MODE_STRT] || sin_f); // [R6]
   assign wr_fire = q.aw_got && q.w_got && !q.bvalid;
   assign sout_int = pha ? q.out_q : q.sr[7]; // [R1] [R2] [R15]
   always_comb begin
      // Master edges come from the divider, slave edges from the clock pin
      if (master) begin // [R3] [R4]
         lead_ev = tk.lead;
         trail_ev = tk.trail;
      end else begin // [R19]
         lead_ev = (sck_f ^ pol) && !(q.sck_prev ^ pol); // [R9]
         trail_ev = !(sck_f ^ pol) && (q.sck_prev ^ pol); // [R9]
      end
   end
   always_comb begin
      wr_ok = 1'h1;
      case (q.aw_addr)
         ADDR_DATA, ADDR_DIV, ADDR_MODE, ADDR_MISC: wr_ok = 1'h1;
         ADDR_STS, ADDR_ICLR, ADDR_IEN: wr_ok = 1'h1;
         default: wr_ok = 1'h0;
      endcase
   end
   always_comb begin
      rd_ok = 1'h1;
      case (s_axi_araddr)
         ADDR_DATA: rd_val = q.sr; // [R11]
         ADDR_DIV: rd_val = q.div;
         ADDR_MODE: rd_val = q.mode;
         ADDR_MISC: rd_val = q.misc;
         ADDR_STS: rd_val = {6'h00, q.sts};
         ADDR_ICLR: rd_val = 8'h00;
         ADDR_IEN: rd_val = {6'h00, q.ien};
         default: begin
            rd_val = 8'h00;
            rd_ok = 1'h0;
         end
      endcase
   end
   always_comb begin
      d = q;
      end_ev = 1'h0;
      d.sck_m = sck_in;
      d.sck_s = q.sck_m;
      d.sin_m = sin;
      d.sin_s = q.sin_m;
      d.sck_prev = sck_f;
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_got = 1'h1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_got = 1'h1;
         d.w_data = s_axi_wdata[7:0];
         d.w_be = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'h0;
      end
      if (wr_fire) begin
         d.aw_got = 1'h0;
         d.w_got = 1'h0;
         d.bvalid = 1'h1;
         d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'h0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'h1;
         d.rdata = rd_val;
         d.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (wr_fire && q.w_be) begin
         case (q.aw_addr)
            ADDR_DATA: begin
               if (!q.mode[MODE_RUN]) begin // [R11]
                  d.sr = q.w_data;
               end
            end
            ADDR_DIV: begin
               if (!q.mode[MODE_RUN]) begin // [R10]
                  d.div[6:0] = q.w_data[6:0];
                  if (!q.w_data[DIV_FLAG]) begin // [R12]
                     d.div[DIV_FLAG] = 1'h0;
                  end
               end
            end
            ADDR_MODE: d.mode = q.w_data;
            ADDR_MISC: d.misc = q.w_data;
            ADDR_ICLR: d.sts = q.sts & ~q.w_data[1:0];
            ADDR_IEN: d.ien = q.w_data[1:0];
            default: ;
         endcase
      end
      abort_ev = (q.state != ST_IDLE) && !d.mode[MODE_RUN];
      if (abort_ev) begin // [R17]
         d.state = ST_IDLE;
         d.sck_q = 1'h0;
         d.div[DIV_FLAG] = 1'h1;
         d.sts[STS_ABORT] = 1'h1;
      end else begin
         case (q.state)
            ST_IDLE, ST_WAIT: begin
               if (go) begin // [R6]
                  d.state = ST_SHIFT;
                  d.bit_cnt = 4'h0;
                  d.lead_done = 1'h0;
                  d.out_q = 1'h0;
                  d.smp = 1'h0;
                  d.sck_q = 1'h0;
               end else if (q.mode[MODE_RUN]) begin
                  d.state = ST_WAIT;
               end
            end
            ST_SHIFT: begin
               // Serial input level no longer gates the transfer once shifting
               if (lead_ev) begin // [R7]
                  d.sck_q = 1'h1;
                  if (!pha) begin
                     d.smp = in_bit; // [R5]
                  end else begin
                     d.out_q = q.sr[7]; // [R2]
                     d.lead_done = 1'h1;
                  end
               end
               if (trail_ev) begin
                  d.sck_q = 1'h0;
                  d.sr = {q.sr[6:0], pha ? in_bit : q.smp}; // [R15]
                  d.bit_cnt = q.bit_cnt + 4'h1;
                  if (q.bit_cnt == last_bit) begin // [R13]
                     end_ev = 1'h1;
                     d.state = ST_IDLE;
                     d.mode[MODE_RUN] = 1'h0; // [R17]
                     d.div[DIV_FLAG] = 1'h1; // [R12]
                     d.sts[STS_DONE] = 1'h1;
                  end
               end
            end
            default: d.state = ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         q <= '0;
         q.state <= ST_IDLE;
         q.mode <= RST_MODE; // [R18]
         q.div <= RST_DIV; // [R10]
         q.sr <= RST_DATA;
         q.misc <= RST_MISC;
         q.ien <= RST_IEN;
      end else begin
         q <= d;
      end
   end
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = {24'h000000, q.rdata};
   assign irq = (|(q.sts & q.ien)) || (q.div[DIV_FLAG] && q.mode[MODE_IE]); // [R12]
   assign sck_out = q.sck_q ^ pol; // [R4] [R9]
   assign sck_oe = master; // [R4]
   assign shared_pin_out = q.misc[0] ? sout_int : port_dout; // [R16]
   assign shared_pin_oe = q.misc[0] ? 1'h1 : port_oe; // [R16]

   load_msb_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_fire && q.w_be && q.aw_addr == ADDR_DATA && !q.mode[MODE_RUN] && !pha
      |=> sout_int == $past(q.w_data[7])) else $error("msb not shown on load"); // [R1]
   shifted_msb_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.state == ST_SHIFT && pha && !q.lead_done |-> sout_int == 1'h0) else $error("msb shown early"); // [R2]
   idle_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.state == ST_IDLE |-> sck_out == pol) else $error("clock not at idle level"); // [R9]
   rx_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.state == ST_SHIFT && lead_ev && !pha && !q.mode[MODE_RX_EN] && !wr_fire
      |=> !q.smp) else $error("input not forced to zero"); // [R5]
   free_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.state != ST_SHIFT && q.mode[MODE_RUN] && !q.mode[MODE_STRT] && !wr_fire
      |=> q.state == ST_SHIFT) else $error("transfer did not start"); // [R6]
   gated_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.state == ST_SHIFT && !sin_f && !wr_fire && !end_ev |=> q.state == ST_SHIFT)
      else $error("gated transfer dropped"); // [R7]
   div_locked_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_fire && q.aw_addr == ADDR_DIV && q.mode[MODE_RUN] |=> $stable(q.div[6:0]))
      else $error("divider written while active"); // [R10]
   data_locked_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_fire && q.aw_addr == ADDR_DATA && q.mode[MODE_RUN] && !trail_ev |=> $stable(q.sr))
      else $error("data written while active"); // [R11]
   end_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      end_ev |=> q.div[DIV_FLAG] && q.sts[STS_DONE] && !q.mode[MODE_RUN])
      else $error("end of transfer not flagged"); // [R12]
   frame_count_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      end_ev |-> q.bit_cnt == last_bit) else $error("wrong frame length"); // [R13]
   abort_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      abort_ev |=> q.state == ST_IDLE && q.sts[STS_ABORT] && q.div[DIV_FLAG])
      else $error("abort not handled"); // [R17]
   pin_route_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.misc[0] && q.state == ST_SHIFT |-> shared_pin_oe && shared_pin_out == sout_int)
      else $error("serial output not on pin"); // [R16]
endmodule
`default_nettype wire

/* File: spi_tick_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface spi_tick_if;
   logic run;
   logic [2:0] rate;
   logic core_tick;
   logic lead;
   logic trail;
   modport gen (input run, input rate, output core_tick, output lead, output trail);
   modport eng (output run, output rate, input core_tick, input lead, input trail);
endinterface
`default_nettype wire

/* File: tb_serial_peripheral_interface.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_peripheral_interface
   import spi_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic irq, sck_out, sck_oe, shared_pin_out, shared_pin_oe, miso, sin;
   logic sck_in = 1'b0, port_dout = 1'b0, port_oe = 1'b0;
   logic pol_q = 1'b0, pha_q = 1'b0, m_load = 1'b0, gate_ovr = 1'b0, gate_lvl = 1'b0;
   logic [7:0] m_val = 8'h00, rx_m;
   int n_fail = 0;
   int check_count = 0;
   assign sin = gate_ovr ? gate_lvl : miso;
   initial forever #10 clk_sys = ~clk_sys;
   spi_serial_port dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
      .sck_in, .sck_out, .sck_oe, .sin, .port_dout, .port_oe, .shared_pin_out, .shared_pin_oe);
   spi_far_model far (.sck(sck_out), .mosi(shared_pin_out), .pol(pol_q), .pha(pha_q), .load(m_load),
      .load_val(m_val), .miso(miso), .rx_q(rx_m));
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int t = 0;
      logic aw = 1'b1;
      logic w = 1'b1;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         t++;
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1 && t < 100);
      s_axi_bready <= 1'b0;
      if (t >= 100) n_fail++;
      cmp8({6'h00, s_axi_bresp}, {6'h00, er});
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
      int t = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 100);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      if (t >= 100) n_fail++;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      cmp8({6'h00, r}, {6'h00, RESP_OKAY});
      cmp8(d, e);
   endtask
   task automatic wait_idle;
      logic [7:0] d;
      logic [1:0] r;
      int t = 0;
      do begin
         axi_rd(ADDR_MODE, d, r);
         t++;
      end while (d[MODE_RUN] !== 1'b0 && t < 2000);
      if (t >= 2000) n_fail++;
   endtask
   // Master frame of 8 bits at full rate, both directions checked
   task automatic xfer(input logic p, input logic h, input logic [7:0] d, input logic [7:0] m);
      logic [7:0] md;
      md = {6'h13, p, h};
      pol_q <= p;
      pha_q <= h;
      axi_wr(ADDR_MODE, md, RESP_OKAY);
      cmp1(sck_out, p);
      cmp1(sck_oe, 1'b1);
      axi_wr(ADDR_DATA, d, RESP_OKAY);
      axi_wr(ADDR_DIV, 8'h40, RESP_OKAY);
      if (!h) cmp1(shared_pin_out, d[7]);
      m_val <= m;
      m_load <= 1'b1;
      @(posedge clk_sys);
      m_load <= 1'b0;
      axi_wr(ADDR_MODE, md | 8'h80, RESP_OKAY);
      wait_idle;
      cmp8(rx_m, d);
      rd_chk(ADDR_DATA, m);
      rd_chk(ADDR_DIV, 8'hc0);
      cmp1(irq, 1'b1);
      axi_wr(ADDR_DIV, 8'h40, RESP_OKAY);
      cmp1(irq, 1'b0);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_fail++;
      finish_test;
   end
   initial begin
      logic [7:0] d;
      logic [1:0] r;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd_chk(ADDR_DATA, RST_DATA);
      rd_chk(ADDR_DIV, RST_DIV);
      rd_chk(ADDR_MODE, RST_MODE);
      rd_chk(ADDR_MISC, RST_MISC);
      rd_chk(ADDR_IEN, {6'h00, RST_IEN});
      cmp1(irq, 1'b0);
      axi_rd(8'h1c, d, r);
      cmp8({6'h00, r}, {6'h00, RESP_SLVERR});
      cmp8(d, 8'h00);
      axi_wr(8'h1c, 8'hff, RESP_SLVERR);
      port_dout <= 1'b1;
      @(posedge clk_sys);
      cmp1(shared_pin_out, 1'b1);
      cmp1(shared_pin_oe, 1'b0);
      axi_wr(ADDR_MISC, 8'h01, RESP_OKAY);
      cmp1(shared_pin_oe, 1'b1);
      for (int i = 0; i < 4; i++) xfer(i[1], i[0], 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
      // Writes during a running frame must not land; receive off shifts in zeros
      pol_q <= 1'b0;
      pha_q <= 1'b0;
      axi_wr(ADDR_DIV, 8'h41, RESP_OKAY);
      axi_wr(ADDR_DATA, 8'h96, RESP_OKAY);
      axi_wr(ADDR_MODE, 8'h84, RESP_OKAY);
      axi_wr(ADDR_DATA, 8'h5a, RESP_OKAY);
      axi_wr(ADDR_DIV, 8'h00, RESP_OKAY);
      wait_idle;
      rd_chk(ADDR_DIV, 8'hc1);
      rd_chk(ADDR_DATA, 8'h00);
      cmp8(rx_m, 8'h96);
      // Abort at the slowest rate, then interrupt raise, mask and clear
      axi_wr(ADDR_ICLR, 8'h03, RESP_OKAY);
      axi_wr(ADDR_DIV, 8'h47, RESP_OKAY);
      axi_wr(ADDR_MODE, 8'h84, RESP_OKAY);
      axi_wr(ADDR_MODE, 8'h04, RESP_OKAY);
      rd_chk(ADDR_STS, 8'h02);
      rd_chk(ADDR_DIV, 8'hc7);
      cmp1(irq, 1'b0);
      axi_wr(ADDR_IEN, 8'h02, RESP_OKAY);
      cmp1(irq, 1'b1);
      axi_wr(ADDR_IEN, 8'h01, RESP_OKAY);
      cmp1(irq, 1'b0);
      axi_wr(ADDR_IEN, 8'h02, RESP_OKAY);
      axi_wr(ADDR_STS, 8'h00, RESP_OKAY);
      cmp1(irq, 1'b1);
      axi_wr(ADDR_ICLR, 8'h02, RESP_OKAY);
      cmp1(irq, 1'b0);
      // Gated start: waits for input high, then survives its drop
      axi_wr(ADDR_IEN, 8'h00, RESP_OKAY);
      axi_wr(ADDR_DIV, 8'h40, RESP_OKAY);
      gate_ovr <= 1'b1;
      axi_wr(ADDR_MODE, 8'h94, RESP_OKAY);
      repeat (100) @(posedge clk_sys);
      rd_chk(ADDR_STS, 8'h00);
      rd_chk(ADDR_MODE, 8'h94);
      gate_lvl <= 1'b1;
      repeat (40) @(posedge clk_sys);
      gate_lvl <= 1'b0;
      wait_idle;
      rd_chk(ADDR_STS, 8'h01);
      // Slave frame clocked from the pin through the filters, after a short glitch
      gate_ovr <= 1'b0;
      axi_wr(ADDR_DIV, 8'h40, RESP_OKAY);
      axi_wr(ADDR_DATA, 8'hc3, RESP_OKAY);
      m_val <= 8'h81;
      m_load <= 1'b1;
      @(posedge clk_sys);
      m_load <= 1'b0;
      axi_wr(ADDR_MODE, 8'ha8, RESP_OKAY);
      cmp1(sck_oe, 1'b0);
      sck_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sck_in <= 1'b0;
      repeat (60) @(posedge clk_sys);
      for (int b = 0; b < 8; b++) begin
         sck_in <= 1'b1;
         repeat (50) @(posedge clk_sys);
         sck_in <= 1'b0;
         repeat (50) @(posedge clk_sys);
      end
      wait_idle;
      cmp8(rx_m, 8'hc3);
      rd_chk(ADDR_DATA, 8'h81);
      finish_test;
   end
endmodule
`default_nettype wire
